// ==== fmmp_ahb.v ====
`timescale 1ns/1ns
`default_nettype none
`include "fmmp_defs.vh"

module fmmp_ahb
(
    input  wire        clk,
    input  wire        nrst,
    input  wire        cmd_valid,
    output wire        cmd_ready,
    input  wire        cmd_write,
    input  wire        cmd_lock,
    input  wire [1:0]  cmd_size,
    input  wire [31:0] cmd_addr,
    input  wire [31:0] cmd_wdata,
    output reg         done,
    output reg  [31:0] rdata,
    output reg         err,
    output reg  [31:0] haddr,
    output reg  [1:0]  htrans,
    output reg         hwrite,
    output reg  [1:0]  hsize,
    output wire [1:0]  hburst,
    output reg         hmastlock,
    output reg  [31:0] hwdata,
    input  wire [31:0] hrdata,
    input  wire        hready,
    input  wire        hresp
);

    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_DATA = 3'h4;

    reg [2:0]  state;
    reg [31:0] wdata_hold;

    // Single transfers only, so the burst code never changes
    assign hburst    = `FMMP_HBURST_SINGLE;
    assign cmd_ready = (state == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Address phase, then data phase; each ends only on a sampled HREADY
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state      <= ST_IDLE;
            haddr      <= 32'h0;
            htrans     <= `FMMP_HTRANS_IDLE;
            hwrite     <= 1'b0;
            hsize      <= `FMMP_HSIZE_BYTE;
            hmastlock  <= 1'b0;
            hwdata     <= 32'h0;
            wdata_hold <= 32'h0;
            done       <= 1'b0;
            rdata      <= 32'h0;
            err        <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        haddr  <= cmd_addr;
                        htrans <= `FMMP_HTRANS_NONSEQ;
                        hwrite <= cmd_write;
                        hsize  <= (cmd_size > `FMMP_HSIZE_WORD) ?
                                  `FMMP_HSIZE_WORD : cmd_size;
                        hmastlock  <= cmd_lock;
                        wdata_hold <= cmd_wdata;
                        state  <= ST_ADDR;
                    end
                end
                ST_ADDR:
                begin
                    if (hready)
                    begin
                        htrans <= `FMMP_HTRANS_IDLE;
                        hwdata <= wdata_hold;
                        state  <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (hready)
                    begin
                        rdata <= hwrite ? 32'h0 : hrdata;
                        err   <= hresp;
                        done  <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state  <= ST_IDLE;
                    htrans <= `FMMP_HTRANS_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== fmmp_axi_enc.v ====
`timescale 1ns/1ns
`default_nettype none
`include "fmmp_defs.vh"

module fmmp_axi_enc
(
    input  wire [4:0] beats,
    input  wire [1:0] burst_in,
    input  wire [1:0] lock_in,
    output reg  [3:0] len,
    output reg  [1:0] burst,
    output reg  [1:0] lock
);

    reg [4:0] clamped;

    ////////////////////////////////////////////////////////////////////////
    // Legalise a request before it reaches the address channel
    always @*
    begin
        clamped = beats;
        if (beats < `FMMP_BEATS_MIN)
            clamped = `FMMP_BEATS_MIN;
        else if (beats > `FMMP_BEATS_MAX)
            clamped = `FMMP_BEATS_MAX;
        len = clamped[3:0] - 4'h1;
        burst = (burst_in == `FMMP_BURST_RSVD) ? `FMMP_BURST_INCR : burst_in;
        lock = (lock_in == `FMMP_LOCK_RSVD) ? `FMMP_LOCK_NORMAL : lock_in;
    end

endmodule

`default_nettype wire

// ==== fmmp_defs.vh ====
`ifndef FMMP_DEFS_VH
`define FMMP_DEFS_VH

// Burst type codes of the wide port
`define FMMP_BURST_FIXED  2'h0
`define FMMP_BURST_INCR   2'h1
`define FMMP_BURST_WRAP   2'h2
`define FMMP_BURST_RSVD   2'h3

// Beat size codes of the wide port, 1/2/4/8 bytes
`define FMMP_SIZE_1B      2'h0
`define FMMP_SIZE_2B      2'h1
`define FMMP_SIZE_4B      2'h2
`define FMMP_SIZE_8B      2'h3

// Lock codes, shared by both address channels
`define FMMP_LOCK_NORMAL  2'h0
`define FMMP_LOCK_EXCL    2'h1
`define FMMP_LOCK_LOCKED  2'h2
`define FMMP_LOCK_RSVD    2'h3

// Response codes, shared by read and write
`define FMMP_RESP_OKAY    2'h0
`define FMMP_RESP_EXOKAY  2'h1
`define FMMP_RESP_SLVERR  2'h2
`define FMMP_RESP_DECERR  2'h3

// Burst length: encoded value plus one is the beat count
`define FMMP_LEN_W        4
`define FMMP_BEATS_W      5
`define FMMP_BEATS_MIN    5'h01
`define FMMP_BEATS_MAX    5'h10

// Narrow port transfer types
`define FMMP_HTRANS_IDLE   2'h0
`define FMMP_HTRANS_BUSY   2'h1
`define FMMP_HTRANS_NONSEQ 2'h2
`define FMMP_HTRANS_SEQ    2'h3

// Narrow port transfer sizes and burst
`define FMMP_HSIZE_BYTE   2'h0
`define FMMP_HSIZE_HALF   2'h1
`define FMMP_HSIZE_WORD   2'h2
`define FMMP_HBURST_SINGLE 2'h0

`endif

// ==== fmmp_slave.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Fabric memory controller model
module fmmp_slave
(
    input wire logic        CLK, NRST, slow, AXI_ARVALID, AXI_RREADY, AXI_AWVALID,
    input wire logic        AXI_WVALID, AXI_WLAST, AXI_BREADY,
    input wire logic [1:0]  AHB_HTRANS,
    input wire logic [3:0]  AXI_ARID, AXI_ARLEN, AXI_AWID,
    input wire logic [31:0] AXI_ARADDR, AHB_HADDR,
    output logic            AXI_ARREADY, AXI_AWREADY, AXI_WREADY, AHB_HREADY,
    output logic            AXI_RVALID, AXI_BVALID, AXI_RLAST,
    output logic [3:0]      AXI_RID, AXI_BID,
    output logic [63:0]     AXI_RDATA,
    output logic [31:0]     AHB_HRDATA
);
    logic [3:0]  beat, len;
    logic [31:0] ra, ha;
    logic [7:0]  cyc;
    logic        rbusy, aw, wd, dp, ok;

    // Slow mode: ready one cycle in four
    assign ok = !slow || cyc[1:0] == 2'h3;
    assign {AXI_ARREADY, AXI_AWREADY, AXI_WREADY} = {3{ok}};
    assign AHB_HREADY = ok;
    assign AXI_RLAST = AXI_RVALID && beat == len;
    // Idle bus shows a moving pattern
    assign AXI_RDATA = {ra, 24'h000000, AXI_RVALID ? {AXI_RID, beat} : cyc};
    assign AHB_HRDATA = dp ? ~ha : {4{cyc}};

    // Channel sequencing
    always @(posedge CLK)
    begin
        cyc <= cyc + 8'h01;
        if (!NRST)
        begin
            cyc <= 8'h00;
            {AXI_RVALID, AXI_BVALID, rbusy, aw, wd, dp} <= 6'h00;
        end
        else
        begin
            if (AXI_ARVALID && ok)
            begin
                AXI_RID <= AXI_ARID;
                ra <= AXI_ARADDR;
                len <= AXI_ARLEN;
                beat <= 4'h0;
                rbusy <= 1'b1;
            end
            // Valid held until ready
            if (AXI_RVALID && AXI_RREADY)
            begin
                AXI_RVALID <= 1'b0;
                beat <= beat + 4'h1;
                rbusy <= !AXI_RLAST;
            end
            else if (rbusy && ok)
                AXI_RVALID <= 1'b1;
            if (AXI_AWVALID && ok)
            begin
                AXI_BID <= AXI_AWID;
                aw <= 1'b1;
            end
            if (AXI_WVALID && ok && AXI_WLAST)
                wd <= 1'b1;
            if (AXI_BVALID && AXI_BREADY)
            begin
                AXI_BVALID <= 1'b0;
                aw <= 1'b0;
                wd <= 1'b0;
            end
            else if (aw && wd && ok)
                AXI_BVALID <= 1'b1;
            if (ok)
            begin
                dp <= AHB_HTRANS[1];
                ha <= AHB_HADDR;
            end
        end
    end
endmodule

`default_nettype wire

// ==== fmmp_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "fmmp_defs.vh"

module fmmp_top
(
    input  wire        CLK,
    input  wire        NRST,
    // Read command
    input  wire        RD_REQ_VALID,
    output wire        RD_REQ_READY,
    input  wire [31:0] RD_REQ_ADDR,
    input  wire [3:0]  RD_REQ_ID,
    input  wire [4:0]  RD_REQ_BEATS,
    input  wire [1:0]  RD_REQ_SIZE,
    input  wire [1:0]  RD_REQ_BURST,
    input  wire [1:0]  RD_REQ_LOCK,
    // Read data toward the user
    output reg         RD_DAT_VALID,
    output reg  [63:0] RD_DAT,
    output reg  [3:0]  RD_DAT_ID,
    output reg  [1:0]  RD_DAT_RESP,
    output reg         RD_DAT_ERR,
    output reg         RD_DAT_LAST,
    // Write command
    input  wire        WR_REQ_VALID,
    output wire        WR_REQ_READY,
    input  wire [31:0] WR_REQ_ADDR,
    input  wire [3:0]  WR_REQ_ID,
    input  wire [4:0]  WR_REQ_BEATS,
    input  wire [1:0]  WR_REQ_SIZE,
    input  wire [1:0]  WR_REQ_BURST,
    input  wire [1:0]  WR_REQ_LOCK,
    // Write data from the user
    input  wire        WR_DAT_VALID,
    output wire        WR_DAT_READY,
    input  wire [63:0] WR_DAT,
    input  wire [7:0]  WR_DAT_STRB,
    // Write response toward the user
    output reg         WR_RSP_VALID,
    output reg  [3:0]  WR_RSP_ID,
    output reg  [1:0]  WR_RSP_CODE,
    output reg         WR_RSP_ERR,
    // Narrow command
    input  wire        HB_REQ_VALID,
    output wire        HB_REQ_READY,
    input  wire        HB_REQ_WRITE,
    input  wire        HB_REQ_LOCK,
    input  wire [1:0]  HB_REQ_SIZE,
    input  wire [31:0] HB_REQ_ADDR,
    input  wire [31:0] HB_REQ_WDATA,
    output wire        HB_DONE,
    output wire [31:0] HB_RDATA,
    output wire        HB_ERR,
    // Wide fabric master, write address channel
    output reg  [3:0]  AXI_AWID,
    output reg  [31:0] AXI_AWADDR,
    output reg  [3:0]  AXI_AWLEN,
    output reg  [1:0]  AXI_AWSIZE,
    output reg  [1:0]  AXI_AWBURST,
    output reg  [1:0]  AXI_AWLOCK,
    output reg         AXI_AWVALID,
    input  wire        AXI_AWREADY,
    // Write data channel
    output reg  [3:0]  AXI_WID,
    output reg  [63:0] AXI_WDATA,
    output reg  [7:0]  AXI_WSTRB,
    output reg         AXI_WLAST,
    output reg         AXI_WVALID,
    input  wire        AXI_WREADY,
    // Write response channel
    input  wire [3:0]  AXI_BID,
    input  wire [1:0]  AXI_BRESP,
    input  wire        AXI_BVALID,
    output reg         AXI_BREADY,
    // Read address channel
    output reg  [3:0]  AXI_ARID,
    output reg  [31:0] AXI_ARADDR,
    output reg  [3:0]  AXI_ARLEN,
    output reg  [1:0]  AXI_ARSIZE,
    output reg  [1:0]  AXI_ARBURST,
    output reg  [1:0]  AXI_ARLOCK,
    output reg         AXI_ARVALID,
    input  wire        AXI_ARREADY,
    // Read data channel
    input  wire [3:0]  AXI_RID,
    input  wire [63:0] AXI_RDATA,
    input  wire [1:0]  AXI_RRESP,
    input  wire        AXI_RLAST,
    input  wire        AXI_RVALID,
    output reg         AXI_RREADY,
    // Narrow fabric master
    output wire [31:0] AHB_HADDR,
    output wire [1:0]  AHB_HTRANS,
    output wire        AHB_HWRITE,
    output wire [1:0]  AHB_HSIZE,
    output wire [1:0]  AHB_HBURST,
    output wire        AHB_HMASTLOCK,
    output wire [31:0] AHB_HWDATA,
    input  wire [31:0] AHB_HRDATA,
    input  wire        AHB_HREADY,
    input  wire        AHB_HRESP
);

    localparam [2:0] RD_IDLE = 3'h1;
    localparam [2:0] RD_ADDR = 3'h2;
    localparam [2:0] RD_DATA = 3'h4;

    localparam [2:0] WR_IDLE = 3'h1;
    localparam [2:0] WR_BEAT = 3'h2;
    localparam [2:0] WR_RESP = 3'h4;

    reg  [2:0] rd_state;
    reg  [2:0] wr_state;
    reg  [4:0] wr_left;
    wire       w_load;
    wire [3:0] rd_len;
    wire [1:0] rd_burst;
    wire [1:0] rd_lock;
    wire [3:0] wr_len;
    wire [1:0] wr_burst;
    wire [1:0] wr_lock;

    ////////////////////////////////////////////////////////////////////////
    // Request legalisation, one encoder per address channel
    fmmp_axi_enc u_rd_enc
    (
        .beats    (RD_REQ_BEATS),
        .burst_in (RD_REQ_BURST),
        .lock_in  (RD_REQ_LOCK),
        .len      (rd_len),
        .burst    (rd_burst),
        .lock     (rd_lock)
    );

    fmmp_axi_enc u_wr_enc
    (
        .beats    (WR_REQ_BEATS),
        .burst_in (WR_REQ_BURST),
        .lock_in  (WR_REQ_LOCK),
        .len      (wr_len),
        .burst    (wr_burst),
        .lock     (wr_lock)
    );

    // One transaction per direction in flight; keeps ID matching trivial
    assign RD_REQ_READY = (rd_state == RD_IDLE);
    assign WR_REQ_READY = (wr_state == WR_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Read path: address handshake, then beats until the last one
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            rd_state     <= RD_IDLE;
            AXI_ARID     <= 4'h0;
            AXI_ARADDR   <= 32'h0;
            AXI_ARLEN    <= 4'h0;
            AXI_ARSIZE   <= `FMMP_SIZE_1B;
            AXI_ARBURST  <= `FMMP_BURST_FIXED;
            AXI_ARLOCK   <= `FMMP_LOCK_NORMAL;
            AXI_ARVALID  <= 1'b0;
            AXI_RREADY   <= 1'b0;
            RD_DAT_VALID <= 1'b0;
            RD_DAT       <= 64'h0;
            RD_DAT_ID    <= 4'h0;
            RD_DAT_RESP  <= `FMMP_RESP_OKAY;
            RD_DAT_ERR   <= 1'b0;
            RD_DAT_LAST  <= 1'b0;
        end
        else
        begin
            RD_DAT_VALID <= 1'b0;
            case (rd_state)
                RD_IDLE:
                begin
                    if (RD_REQ_VALID)
                    begin
                        AXI_ARID    <= RD_REQ_ID;
                        AXI_ARADDR  <= RD_REQ_ADDR;
                        AXI_ARLEN   <= rd_len;
                        AXI_ARSIZE  <= RD_REQ_SIZE;
                        AXI_ARBURST <= rd_burst;
                        AXI_ARLOCK  <= rd_lock;
                        AXI_ARVALID <= 1'b1;
                        rd_state    <= RD_ADDR;
                    end
                end
                RD_ADDR:
                begin
                    if (AXI_ARREADY)
                    begin
                        AXI_ARVALID <= 1'b0;
                        AXI_RREADY  <= 1'b1;
                        rd_state    <= RD_DATA;
                    end
                end
                RD_DATA:
                begin
                    if (AXI_RVALID)
                    begin
                        RD_DAT_VALID <= 1'b1;
                        RD_DAT       <= AXI_RDATA;
                        RD_DAT_ID    <= AXI_RID;
                        RD_DAT_RESP  <= AXI_RRESP;
                        RD_DAT_ERR   <= AXI_RRESP[1];
                        RD_DAT_LAST  <= AXI_RLAST;
                        if (AXI_RLAST)
                        begin
                            AXI_RREADY <= 1'b0;
                            rd_state   <= RD_IDLE;
                        end
                    end
                end
                default:
                begin
                    rd_state    <= RD_IDLE;
                    AXI_ARVALID <= 1'b0;
                    AXI_RREADY  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write data takes a user beat whenever beats remain and the output stage is free
    assign w_load       = (wr_state == WR_BEAT) && (wr_left != 5'h00) &&
                          (!AXI_WVALID || AXI_WREADY);
    assign WR_DAT_READY = w_load;

    ////////////////////////////////////////////////////////////////////////
    // Write path: address and data run side by side, then the response
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            wr_state     <= WR_IDLE;
            wr_left      <= 5'h00;
            AXI_AWID     <= 4'h0;
            AXI_AWADDR   <= 32'h0;
            AXI_AWLEN    <= 4'h0;
            AXI_AWSIZE   <= `FMMP_SIZE_1B;
            AXI_AWBURST  <= `FMMP_BURST_FIXED;
            AXI_AWLOCK   <= `FMMP_LOCK_NORMAL;
            AXI_AWVALID  <= 1'b0;
            AXI_WID      <= 4'h0;
            AXI_WDATA    <= 64'h0;
            AXI_WSTRB    <= 8'h00;
            AXI_WLAST    <= 1'b0;
            AXI_WVALID   <= 1'b0;
            AXI_BREADY   <= 1'b0;
            WR_RSP_VALID <= 1'b0;
            WR_RSP_ID    <= 4'h0;
            WR_RSP_CODE  <= `FMMP_RESP_OKAY;
            WR_RSP_ERR   <= 1'b0;
        end
        else
        begin
            WR_RSP_VALID <= 1'b0;
            if (AXI_AWVALID && AXI_AWREADY)
                AXI_AWVALID <= 1'b0;
            case (wr_state)
                WR_IDLE:
                begin
                    if (WR_REQ_VALID)
                    begin
                        AXI_AWID    <= WR_REQ_ID;
                        AXI_AWADDR  <= WR_REQ_ADDR;
                        AXI_AWLEN   <= wr_len;
                        AXI_AWSIZE  <= WR_REQ_SIZE;
                        AXI_AWBURST <= wr_burst;
                        AXI_AWLOCK  <= wr_lock;
                        AXI_AWVALID <= 1'b1;
                        AXI_WID     <= WR_REQ_ID;
                        wr_left     <= {1'b0, wr_len} + 5'h01;
                        wr_state    <= WR_BEAT;
                    end
                end
                WR_BEAT:
                begin
                    if (w_load && WR_DAT_VALID)
                    begin
                        AXI_WDATA  <= WR_DAT;
                        AXI_WSTRB  <= WR_DAT_STRB;
                        AXI_WLAST  <= (wr_left == 5'h01);
                        AXI_WVALID <= 1'b1;
                        wr_left    <= wr_left - 5'h01;
                    end
                    else if (AXI_WVALID && AXI_WREADY)
                    begin
                        AXI_WVALID <= 1'b0;
                        AXI_WLAST  <= 1'b0;
                    end
                    // Last beat gone and address taken: wait for the answer
                    if ((wr_left == 5'h00) && (!AXI_WVALID || AXI_WREADY) &&
                        (!AXI_AWVALID || AXI_AWREADY))
                    begin
                        AXI_BREADY <= 1'b1;
                        wr_state   <= WR_RESP;
                    end
                end
                WR_RESP:
                begin
                    if (AXI_BVALID)
                    begin
                        WR_RSP_VALID <= 1'b1;
                        WR_RSP_ID    <= AXI_BID;
                        WR_RSP_CODE  <= AXI_BRESP;
                        WR_RSP_ERR   <= AXI_BRESP[1];
                        AXI_BREADY   <= 1'b0;
                        wr_state     <= WR_IDLE;
                    end
                end
                default:
                begin
                    wr_state    <= WR_IDLE;
                    AXI_AWVALID <= 1'b0;
                    AXI_WVALID  <= 1'b0;
                    AXI_BREADY  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Narrow fabric master; single transfers, stretched by the slave
    fmmp_ahb u_ahb
    (
        .clk       (CLK),
        .nrst      (NRST),
        .cmd_valid (HB_REQ_VALID),
        .cmd_ready (HB_REQ_READY),
        .cmd_write (HB_REQ_WRITE),
        .cmd_lock  (HB_REQ_LOCK),
        .cmd_size  (HB_REQ_SIZE),
        .cmd_addr  (HB_REQ_ADDR),
        .cmd_wdata (HB_REQ_WDATA),
        .done      (HB_DONE),
        .rdata     (HB_RDATA),
        .err       (HB_ERR),
        .haddr     (AHB_HADDR),
        .htrans    (AHB_HTRANS),
        .hwrite    (AHB_HWRITE),
        .hsize     (AHB_HSIZE),
        .hburst    (AHB_HBURST),
        .hmastlock (AHB_HMASTLOCK),
        .hwdata    (AHB_HWDATA),
        .hrdata    (AHB_HRDATA),
        .hready    (AHB_HREADY),
        .hresp     (AHB_HRESP)
    );

endmodule

`default_nettype wire

// ==== fmmp_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Fabric side protocol watch
module fmmp_chk
(
    input wire logic       CLK, NRST, AXI_ARVALID, AXI_ARREADY, AXI_AWVALID, AXI_AWREADY,
    input wire logic       AXI_WVALID, AXI_WREADY, AHB_HREADY,
    input wire logic [3:0] AXI_ARLEN, AXI_AWID, AXI_WID,
    input wire logic [1:0] AXI_ARBURST, AXI_ARLOCK, AXI_AWLOCK, AHB_HTRANS, AHB_HSIZE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_ar_hold:
        assert property (AXI_ARVALID && !AXI_ARREADY |=> AXI_ARVALID && $stable(AXI_ARLEN))
        else $error("ar drop");
    a_aw_hold:
        assert property (AXI_AWVALID && !AXI_AWREADY |=> AXI_AWVALID && $stable(AXI_AWID))
        else $error("aw drop");
    a_w_hold:
        assert property (AXI_WVALID && !AXI_WREADY |=> AXI_WVALID && $stable(AXI_WID))
        else $error("w drop");
    a_arburst_legal:
        assert property (AXI_ARVALID |-> AXI_ARBURST != 2'h3) else $error("ar burst");
    a_arlock_legal:
        assert property (AXI_ARVALID |-> AXI_ARLOCK != 2'h3) else $error("ar lock");
    a_awlock_legal:
        assert property (AXI_AWVALID |-> AXI_AWLOCK != 2'h3) else $error("aw lock");
    a_wid_match:
        assert property (AXI_WVALID |-> AXI_WID == AXI_AWID) else $error("w id");
    a_hsize_legal:
        assert property (AHB_HTRANS != 2'h0 |-> AHB_HSIZE != 2'h3) else $error("h size");
    a_htrans_wait:
        assert property (AHB_HTRANS == 2'h2 && !AHB_HREADY |=> AHB_HTRANS == 2'h2)
        else $error("h stall");
    a_htrans_end:
        assert property (AHB_HTRANS == 2'h2 && AHB_HREADY |=> AHB_HTRANS == 2'h0)
        else $error("h idle");
endmodule

bind fmmp_top fmmp_chk fmmp_chk_inst (.*);

`default_nettype wire

// ==== fmmp_top_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end

////////////////////////////////////////////////////////////////////////////////
module fmmp_top_test;
    logic CLK = 1'b0, NRST = 1'b0, slow = 1'b0, AHB_HRESP, hd;
    logic RD_REQ_VALID, WR_REQ_VALID, WR_DAT_VALID, HB_REQ_VALID, HB_REQ_WRITE, HB_REQ_LOCK;
    logic [1:0] RD_REQ_SIZE, RD_REQ_BURST, RD_REQ_LOCK, AXI_RRESP, WR_REQ_SIZE, WR_REQ_BURST;
    logic [1:0] WR_REQ_LOCK, AXI_BRESP, HB_REQ_SIZE;
    logic [3:0] RD_REQ_ID, WR_REQ_ID;
    logic [4:0] RD_REQ_BEATS, WR_REQ_BEATS;
    logic [31:0] RD_REQ_ADDR, WR_REQ_ADDR, HB_REQ_ADDR, HB_REQ_WDATA;
    logic [31:0] seed = 32'h00013DD8;
    logic [63:0] WR_DAT;
    logic [7:0] WR_DAT_STRB;
    logic [71:0] wx, wq[$];
    wire RD_REQ_READY, RD_DAT_VALID, RD_DAT_ERR, RD_DAT_LAST, WR_REQ_READY, WR_DAT_READY;
    wire WR_RSP_VALID, WR_RSP_ERR, HB_REQ_READY, HB_DONE, HB_ERR, AXI_AWVALID, AXI_WLAST;
    wire AXI_WVALID, AXI_BREADY, AXI_ARVALID, AXI_RREADY, AHB_HWRITE, AHB_HMASTLOCK;
    wire AXI_ARREADY, AXI_AWREADY, AXI_WREADY, AXI_BVALID, AXI_RVALID, AXI_RLAST, AHB_HREADY;
    wire [1:0] RD_DAT_RESP, WR_RSP_CODE, AXI_AWSIZE, AXI_AWBURST, AXI_AWLOCK, AXI_ARSIZE;
    wire [1:0] AXI_ARBURST, AXI_ARLOCK, AHB_HTRANS, AHB_HSIZE, AHB_HBURST;
    wire [3:0] RD_DAT_ID, WR_RSP_ID, AXI_AWID, AXI_AWLEN, AXI_WID, AXI_ARID, AXI_ARLEN;
    wire [3:0] AXI_RID, AXI_BID;
    wire [7:0] AXI_WSTRB;
    wire [31:0] HB_RDATA, AXI_AWADDR, AXI_ARADDR, AHB_HADDR, AHB_HWDATA, AHB_HRDATA;
    wire [63:0] RD_DAT, AXI_WDATA, AXI_RDATA;
    int n_errors = 0, n_compared = 0, cyc = 0, i, b;

    fmmp_top fmmp_top_inst (.*);
    fmmp_slave fmmp_slave_inst (.*);

    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected beat count
    function automatic int nb(input [4:0] v);
        nb = v == 5'h00 ? 1 : v > 5'h10 ? 16 : v;
    endfunction

    task automatic tally_and_finish;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Clock and hang guard
    initial forever #20 CLK = ~CLK;
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 32'h4E20)
        begin
            n_errors++;
            tally_and_finish;
        end
    end

    // Reference model, checked at each handshake
    always @(posedge CLK)
    begin
        if (AXI_ARVALID && AXI_ARREADY)
        begin
            `CHK("arlen", nb(RD_REQ_BEATS) - 1, AXI_ARLEN)
            `CHK("arsize", RD_REQ_SIZE, AXI_ARSIZE)
            `CHK("arburst", RD_REQ_BURST == 2'h3 ? 2'h1 : RD_REQ_BURST, AXI_ARBURST)
            `CHK("arlock", RD_REQ_LOCK == 2'h3 ? 2'h0 : RD_REQ_LOCK, AXI_ARLOCK)
            `CHK("araddr", RD_REQ_ADDR, AXI_ARADDR)
        end
        if (AXI_AWVALID && AXI_AWREADY)
        begin
            `CHK("awaddr", WR_REQ_ADDR, AXI_AWADDR)
            `CHK("awsize", WR_REQ_SIZE, AXI_AWSIZE)
            `CHK("awlock", WR_REQ_LOCK == 2'h3 ? 2'h0 : WR_REQ_LOCK, AXI_AWLOCK)
            `CHK("awburst", WR_REQ_BURST == 2'h3 ? 2'h1 : WR_REQ_BURST, AXI_AWBURST)
            `CHK("awlen", nb(WR_REQ_BEATS) - 1, AXI_AWLEN)
        end
        if (AXI_WVALID && AXI_WREADY)
        begin
            wx = wq.pop_front();
            `CHK("wbeat", wx, {AXI_WSTRB, AXI_WDATA})
            `CHK("wlast", wq.size() == 0, AXI_WLAST)
            `CHK("wid", WR_REQ_ID, AXI_WID)
        end
        if (hd && AHB_HREADY && HB_REQ_WRITE)
            `CHK("hwdata", HB_REQ_WDATA, AHB_HWDATA)
        if (AHB_HREADY)
            hd = AHB_HTRANS == 2'h2;
        if (AHB_HTRANS == 2'h2 && AHB_HREADY)
        begin
            `CHK("haddr", HB_REQ_ADDR, AHB_HADDR)
            `CHK("hwrite", HB_REQ_WRITE, AHB_HWRITE)
            `CHK("hlock", HB_REQ_LOCK, AHB_HMASTLOCK)
            `CHK("hsize", HB_REQ_SIZE == 2'h3 ? 2'h2 : HB_REQ_SIZE, AHB_HSIZE)
        end
        if (HB_DONE)
            `CHK("hrdata", {AHB_HRESP, HB_REQ_WRITE ? 32'h0 : ~HB_REQ_ADDR}, {HB_ERR, HB_RDATA})
        if (RD_DAT_VALID)
        begin
            `CHK("rdata", {RD_REQ_ADDR, 24'h000000, RD_REQ_ID, b[3:0]}, RD_DAT)
            `CHK("rid", RD_REQ_ID, RD_DAT_ID)
            `CHK("rresp", {AXI_RRESP[1], AXI_RRESP}, {RD_DAT_ERR, RD_DAT_RESP})
            `CHK("rlast", b == nb(RD_REQ_BEATS) - 1, RD_DAT_LAST)
            b++;
        end
        if (WR_RSP_VALID)
        begin
            `CHK("bid", WR_REQ_ID, WR_RSP_ID)
            `CHK("bresp", {AXI_BRESP[1], AXI_BRESP}, {WR_RSP_ERR, WR_RSP_CODE})
        end
    end

    // Drivers hold valid until ready
    task automatic rd_go;
        RD_REQ_VALID = 1'b1;
        while (RD_REQ_READY !== 1'b1) @(negedge CLK);
        @(negedge CLK);
        RD_REQ_VALID = 1'b0;
        while (b < nb(RD_REQ_BEATS)) @(negedge CLK);
    endtask
    task automatic wr_go;
        WR_REQ_VALID = 1'b1;
        while (WR_REQ_READY !== 1'b1) @(negedge CLK);
        @(negedge CLK);
        WR_REQ_VALID = 1'b0;
        WR_DAT_VALID = 1'b1;
        repeat (nb(WR_REQ_BEATS))
        begin
            seed = lfsr(seed);
            {WR_DAT_STRB, WR_DAT} = {seed[7:0], seed, ~seed};
            wq.push_back({WR_DAT_STRB, WR_DAT});
            while (WR_DAT_READY !== 1'b1) @(negedge CLK);
            @(negedge CLK);
        end
        WR_DAT_VALID = 1'b0;
        while (WR_RSP_VALID !== 1'b1) @(negedge CLK);
        `CHK("wbeats", 0, wq.size())
    endtask
    task automatic hb_go;
        HB_REQ_VALID = 1'b1;
        while (HB_REQ_READY !== 1'b1) @(negedge CLK);
        @(negedge CLK);
        HB_REQ_VALID = 0;
        while (HB_DONE !== 1'b1) @(negedge CLK);
    endtask

    // All ports busy at once; lengths hit both clamps
    initial
    begin
        repeat (16) @(negedge CLK);
        NRST = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            slow = i[2];
            b = 0;
            {RD_REQ_BURST, WR_REQ_BURST, RD_REQ_LOCK, WR_REQ_LOCK} = {4{i[1:0]}};
            {RD_REQ_SIZE, WR_REQ_SIZE, HB_REQ_SIZE, AXI_RRESP, AXI_BRESP} = {5{i[1:0]}};
            {AHB_HRESP, RD_REQ_ID, WR_REQ_ID, HB_REQ_WRITE, HB_REQ_LOCK} = {seed[8:0], i[1:0]};
            RD_REQ_BEATS = i[2] ? seed[12:8] : {i[1:0], 3'h0};
            WR_REQ_BEATS = i[2] ? seed[17:13] : {i[1:0], 3'h1};
            {RD_REQ_ADDR, WR_REQ_ADDR, HB_REQ_ADDR, HB_REQ_WDATA} = {seed, ~seed, seed ^ 32'h5, ~seed};
            fork
                rd_go;
                wr_go;
                hb_go;
            join
            @(negedge CLK);
        end
        tally_and_finish;
    end
endmodule

`default_nettype wire
